// ---- rtl/fur_top.sv ----
// serial channel rate generation, fifo control, loop-back and apb registers
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ns
`include "fur_params.svh"
module fur_top #(
    parameter int DEPTH = 16
) (
    // clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // interrupt
    output logic             irq,
    // serial pins
    input  wire logic        rxd_pin,
    output logic             txd_pin,
    input  wire logic        ext_clk_pin,
    // frame engine side
    input  wire logic        txd_eng,
    output logic             rxd_eng,
    output logic             tx_avail,
    output logic [7:0]       tx_byte,
    input  wire logic        tx_pop,
    input  wire logic        rx_push,
    input  wire logic [7:0]  rx_byte,
    output logic             sample_tick,
    output logic             bit_tick
);
    localparam int AW = $clog2(DEPTH);

    logic [1:0]            rst_sync_q;
    logic                  rst_n;
    fur_pkg::fur_top_st_t  st_q;
    fur_pkg::fur_top_st_t  st_d;
    logic                  acc;
    logic                  done;
    logic                  wr_done;
    logic                  rd_done;
    logic [7:0]            tx_head;
    logic [7:0]            rx_head;
    logic [AW:0]           tx_cnt;
    logic [AW:0]           rx_cnt;
    logic                  tx_full;
    logic                  tx_empty;
    logic                  rx_full;
    logic                  rx_empty;
    logic                  tx_push;
    logic                  rx_pop;
    logic                  eng_pop;
    logic [2:0]            st_set;
    logic [31:0]           rdata;
    logic                  hit;

    // threshold for each trigger field value
    function automatic logic [4:0] fur_trig(input logic [1:0] sel);
        unique case (sel)
            2'h0: fur_trig = `FUR_TRIG_0;
            2'h1: fur_trig = `FUR_TRIG_1;
            2'h2: fur_trig = `FUR_TRIG_2;
            2'h3: fur_trig = `FUR_TRIG_3;
        endcase
    endfunction : fur_trig

    // reset release through two flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // outputs straight from state
    assign pready   = st_q.pready;
    assign prdata   = st_q.prdata;
    assign pslverr  = st_q.pslverr;
    assign irq      = st_q.irq;
    assign txd_pin  = st_q.txd;
    assign rxd_eng  = st_q.rxd_eng;
    assign tx_avail = st_q.tx_avail;
    assign tx_byte  = st_q.tx_byte;

    // apb phases: answer one cycle into access, effects at the completing edge
    assign acc     = psel && penable && !st_q.pready;
    assign done    = psel && penable && st_q.pready;
    assign wr_done = done && pwrite && !st_q.pslverr;
    assign rd_done = done && !pwrite && !st_q.pslverr;
    assign tx_push = wr_done && (paddr == `FUR_OFS_TX_DATA);
    assign rx_pop  = rd_done && (paddr == `FUR_OFS_RX_DATA);
    assign eng_pop = tx_pop && st_q.tx_avail;

    // read mux and address decode
    always_comb begin
        rdata = 32'h0000_0000;
        hit   = 1'b1;
        unique case (paddr)
            `FUR_OFS_MODE:      rdata[2:0] = {st_q.ext_sel, st_q.prescale};
            `FUR_OFS_DIVISOR:   rdata[7:0] = st_q.divisor;
            `FUR_OFS_FIFO_CTRL: begin
                rdata[`FUR_FC_TRIG_HI:`FUR_FC_TRIG_LO] = st_q.rx_trig;
                rdata[`FUR_FC_TX_RST] = st_q.tx_rst;
                rdata[`FUR_FC_RX_RST] = st_q.rx_rst;
                rdata[`FUR_FC_LOOP]   = st_q.loop;
            end
            `FUR_OFS_STATUS:    rdata[2:0] = st_q.status;
            `FUR_OFS_IRQ_MASK:  rdata[2:0] = st_q.mask;
            `FUR_OFS_TX_DATA:   rdata = 32'h0000_0000;
            `FUR_OFS_RX_DATA:   rdata[7:0] = rx_head;
            `FUR_OFS_COUNT: begin
                rdata[`FUR_COUNT_TX_LSB +: AW+1] = tx_cnt;
                rdata[AW:0] = rx_cnt;
            end
            default:            hit = 1'b0;
        endcase
    end

    // events that set sticky status bits
    always_comb begin
        st_set = 3'h0;
        st_set[`FUR_ST_RX_FULL]  = (int'(rx_cnt) > int'(fur_trig(st_q.rx_trig)));
        st_set[`FUR_ST_RX_OVR]   = rx_push && rx_full;
        st_set[`FUR_ST_TX_EMPTY] = tx_empty;
    end

    // next state
    always_comb begin
        st_d = st_q;
        // apb answer
        st_d.pready = acc;
        if (acc) begin
            st_d.prdata  = hit ? rdata : 32'h0000_0000;
            st_d.pslverr = !hit;
        end else if (done) begin
            st_d.pslverr = 1'b0;
        end
        // register writes
        if (wr_done) begin
            unique case (paddr)
                `FUR_OFS_MODE: begin
                    st_d.prescale = pwdata[1:0];
                    st_d.ext_sel  = pwdata[`FUR_MODE_EXT_BIT];
                end
                `FUR_OFS_DIVISOR:   st_d.divisor = pwdata[7:0];
                `FUR_OFS_FIFO_CTRL: begin
                    st_d.rx_trig = pwdata[`FUR_FC_TRIG_HI:`FUR_FC_TRIG_LO];
                    st_d.tx_rst  = pwdata[`FUR_FC_TX_RST];
                    st_d.rx_rst  = pwdata[`FUR_FC_RX_RST];
                    st_d.loop    = pwdata[`FUR_FC_LOOP];
                end
                `FUR_OFS_IRQ_MASK:  st_d.mask = pwdata[2:0];
                default:            st_d.mask = st_q.mask;
            endcase
        end
        // write one to clear, a set in the same cycle wins
        st_d.status = st_q.status & ~((wr_done && paddr == `FUR_OFS_STATUS) ?
                      pwdata[2:0] : 3'h0);
        st_d.status = st_d.status | st_set;
        st_d.irq    = |(st_d.status & st_d.mask);
        // receive pin: three flops, change counts once stages two and three agree
        st_d.rxd_s = {st_q.rxd_s[1:0], rxd_pin};
        if (st_q.rxd_s[1] == st_q.rxd_s[2]) begin
            st_d.rxd_lvl = st_q.rxd_s[2];
        end
        // loop-back: transmit held at mark, engine hears its own output
        st_d.txd     = st_q.loop ? 1'b1 : txd_eng;
        st_d.rxd_eng = st_q.loop ? txd_eng : st_q.rxd_lvl;
        // head byte offered to the engine, withdrawn for a cycle after each pop
        st_d.tx_avail = !tx_empty && !eng_pop && !st_q.tx_rst;
        st_d.tx_byte  = tx_head;
    end

    // state register, frozen while ce is low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q         <= '0;
            st_q.divisor <= `FUR_DIVISOR_RST;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // transmit fifo: cpu fills, engine drains
    fur_fifo #(.W(8), .D(DEPTH), .AW(AW)) u_tx_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ce        (ce),
        .clr       (st_q.tx_rst),
        .push      (tx_push),
        .push_data (pwdata[7:0]),
        .pop       (eng_pop),
        .head      (tx_head),
        .count     (tx_cnt),
        .full      (tx_full),
        .empty     (tx_empty)
    );

    // receive fifo: engine fills, cpu drains
    fur_fifo #(.W(8), .D(DEPTH), .AW(AW)) u_rx_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ce        (ce),
        .clr       (st_q.rx_rst),
        .push      (rx_push),
        .push_data (rx_byte),
        .pop       (rx_pop),
        .head      (rx_head),
        .count     (rx_cnt),
        .full      (rx_full),
        .empty     (rx_empty)
    );

    // bit rate generator
    fur_rate_gen u_rate (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .ce          (ce),
        .prescale    (st_q.prescale),
        .divisor     (st_q.divisor),
        .ext_sel     (st_q.ext_sel),
        .ext_clk_pin (ext_clk_pin),
        .sample_tick (sample_tick),
        .bit_tick    (bit_tick)
    );
endmodule : fur_top

// ---- rtl/fur_params.svh ----
// register map, field positions, reset values and timing figures for the serial rate/fifo block
`ifndef FUR_PARAMS_SVH
`define FUR_PARAMS_SVH
`define FUR_OFS_MODE      8'h00
`define FUR_OFS_DIVISOR   8'h04
`define FUR_OFS_FIFO_CTRL 8'h08
`define FUR_OFS_STATUS    8'h0C
`define FUR_OFS_IRQ_MASK  8'h10
`define FUR_OFS_TX_DATA   8'h14
`define FUR_OFS_RX_DATA   8'h18
`define FUR_OFS_COUNT     8'h1C
`define FUR_MODE_EXT_BIT  2
`define FUR_FC_TRIG_HI    7
`define FUR_FC_TRIG_LO    6
`define FUR_FC_TX_RST     2
`define FUR_FC_RX_RST     1
`define FUR_FC_LOOP       0
`define FUR_ST_RX_FULL    0
`define FUR_ST_RX_OVR     1
`define FUR_ST_TX_EMPTY   2
`define FUR_DIVISOR_RST   8'hFF
`define FUR_TRIG_0        5'h01
`define FUR_TRIG_1        5'h04
`define FUR_TRIG_2        5'h08
`define FUR_TRIG_3        5'h0E
`define FUR_SAMPLES_BIT   4'hF
`define FUR_COUNT_TX_LSB  8
`endif

// ---- rtl/fur_pkg.sv ----
// state types for the serial rate/fifo block
package fur_pkg;
    typedef struct packed {
        logic [5:0] pre_cnt;
        logic [7:0] div_cnt;
        logic       half;
        logic [3:0] smp_cnt;
        logic [2:0] ext_s;
        logic       ext_lvl;
        logic       sample_tick;
        logic       bit_tick;
    } fur_rate_st_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [1:0]  prescale;
        logic        ext_sel;
        logic [7:0]  divisor;
        logic [1:0]  rx_trig;
        logic        tx_rst;
        logic        rx_rst;
        logic        loop;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic        irq;
        logic [2:0]  rxd_s;
        logic        rxd_lvl;
        logic        txd;
        logic        rxd_eng;
        logic        tx_avail;
        logic [7:0]  tx_byte;
    } fur_top_st_t;
endpackage : fur_pkg

// ---- rtl/fur_fifo.sv ----
// synchronous flip-flop fifo with clear, used for both directions
`timescale 1ns/1ns
module fur_fifo #(
    parameter int W  = 8,
    parameter int D  = 16,
    parameter int AW = 4
) (
    // clock, reset, enable
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    // control
    input  wire logic          clr,
    input  wire logic          push,
    input  wire logic [W-1:0]  push_data,
    input  wire logic          pop,
    // state
    output logic      [W-1:0]  head,
    output logic      [AW:0]   count,
    output logic               full,
    output logic               empty
);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wr;
        logic [AW-1:0]       rd;
        logic [AW:0]         cnt;
    } fur_fifo_st_t;

    fur_fifo_st_t st_q;
    fur_fifo_st_t st_d;
    logic         do_push;
    logic         do_pop;

    // status taken straight from state
    assign count = st_q.cnt;
    assign full  = (st_q.cnt == (AW+1)'(D));
    assign empty = (st_q.cnt == '0);
    assign head  = st_q.mem[st_q.rd];

    // next state: clear discards everything, otherwise push and pop
    always_comb begin
        do_push = push && !full;
        do_pop  = pop && !empty;
        st_d    = st_q;
        if (clr) begin
            st_d.wr  = '0;
            st_d.rd  = '0;
            st_d.cnt = '0;
        end else begin
            if (do_push) begin
                st_d.mem[st_q.wr] = push_data;
                st_d.wr = st_q.wr + 1'b1;
            end
            if (do_pop) begin
                st_d.rd = st_q.rd + 1'b1;
            end
            st_d.cnt = st_q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end
endmodule : fur_fifo

// ---- rtl/fur_rate_gen.sv ----
// bit rate generator: prescaler, divisor and external clock path
`timescale 1ns/1ns
`include "fur_params.svh"
module fur_rate_gen (
    // clock, reset, enable
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // settings
    input  wire logic [1:0] prescale,
    input  wire logic [7:0] divisor,
    input  wire logic       ext_sel,
    input  wire logic       ext_clk_pin,
    // ticks
    output logic            sample_tick,
    output logic            bit_tick
);
    fur_pkg::fur_rate_st_t st_q;
    fur_pkg::fur_rate_st_t st_d;
    logic                  src_tick;
    logic                  half_tick;
    logic                  smp;

    // last prescaler count: 1, 4, 16 or 64 cycles per source tick
    function automatic logic [5:0] fur_pre_last(input logic [1:0] sel);
        unique case (sel)
            2'h0: fur_pre_last = 6'h00;
            2'h1: fur_pre_last = 6'h03;
            2'h2: fur_pre_last = 6'h0F;
            2'h3: fur_pre_last = 6'h3F;
        endcase
    endfunction : fur_pre_last

    assign sample_tick = st_q.sample_tick;
    assign bit_tick    = st_q.bit_tick;

    // internal: (divisor+1)*4^n cycles per half, two halves per sample, 16 samples per bit
    always_comb begin
        st_d      = st_q;
        src_tick  = (st_q.pre_cnt >= fur_pre_last(prescale));
        half_tick = 1'b0;
        st_d.pre_cnt = src_tick ? 6'h00 : st_q.pre_cnt + 6'h01;
        if (src_tick) begin
            if (st_q.div_cnt >= divisor) begin
                st_d.div_cnt = 8'h00;
                half_tick    = 1'b1;
            end else begin
                st_d.div_cnt = st_q.div_cnt + 8'h01;
            end
        end
        if (half_tick) begin
            st_d.half = !st_q.half;
        end
        // external clock: three-flop sync, edge once stages two and three agree
        st_d.ext_s = {st_q.ext_s[1:0], ext_clk_pin};
        if (st_q.ext_s[1] == st_q.ext_s[2]) begin
            st_d.ext_lvl = st_q.ext_s[2];
        end
        if (ext_sel) begin
            smp = st_d.ext_lvl && !st_q.ext_lvl;
        end else begin
            smp = half_tick && st_q.half;
        end
        st_d.sample_tick = smp;
        st_d.bit_tick    = smp && (st_q.smp_cnt == `FUR_SAMPLES_BIT);
        if (smp) begin
            st_d.smp_cnt = st_q.smp_cnt + 4'h1;
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end
endmodule : fur_rate_gen

// ---- bench/fur_top_properties.sv ----
// port assertions for the serial rate/fifo block
`timescale 1ns/1ns
`include "fur_params.svh"
module fur_top_properties (
    // clock, reset
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        ce,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // line, engine, ticks
    input wire logic        txd_pin,
    input wire logic        txd_eng,
    input wire logic        rxd_eng,
    input wire logic        tx_avail,
    input wire logic        ext_clk_pin,
    input wire logic        bit_tick,
    input wire logic        sample_tick
);
    logic [1:0]  pre_q;
    logic [7:0]  div_q;
    logic        ext_q, lp_q, txr_q, ok_q, ep_q;
    logic [3:0]  up_q;
    logic [19:0] cnt_q, per;
    logic [4:0]  ecnt_q;
    logic [3:0]  scnt_q;
    logic        wr;
    assign wr  = psel && penable && pready && pwrite;
    assign per = ({12'h000, div_q} + 20'h00001) << (5 + 2 * pre_q);
    // shadow of written settings; ok_q waits one tick after a change
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pre_q  <= 2'h0;
            ext_q  <= 1'b0;
            div_q  <= 8'hFF;
            lp_q   <= 1'b0;
            txr_q  <= 1'b0;
            ok_q   <= 1'b0;
            ep_q   <= 1'b0;
            up_q   <= 4'h0;
            cnt_q  <= 20'h00000;
            ecnt_q <= 5'h00;
            scnt_q <= 4'h0;
        end else begin
            up_q   <= {up_q[2:0], 1'b1};
            ep_q   <= ext_clk_pin;
            // counters pause with the block while ce is low
            if (ce) begin
                cnt_q  <= bit_tick ? 20'h00000 : cnt_q + 20'h00001;
                ecnt_q <= (bit_tick ? 5'h00 : ecnt_q) + {4'h0, ext_clk_pin & ~ep_q};
                scnt_q <= bit_tick ? 4'h0 : scnt_q + {3'h0, sample_tick};
            end
            ok_q   <= (ok_q | bit_tick) & up_q[3];
            if (wr && paddr == `FUR_OFS_MODE) begin
                pre_q <= pwdata[1:0];
                ext_q <= pwdata[`FUR_MODE_EXT_BIT];
                ok_q  <= 1'b0;
            end
            if (wr && paddr == `FUR_OFS_DIVISOR) begin
                div_q <= pwdata[7:0];
                ok_q  <= 1'b0;
            end
            if (wr && paddr == `FUR_OFS_FIFO_CTRL) begin
                lp_q  <= pwdata[`FUR_FC_LOOP];
                txr_q <= pwdata[`FUR_FC_TX_RST];
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn || !ce);
    a_bit_on_time: assert property (ok_q && !ext_q && cnt_q == per - 20'h1 |-> bit_tick)
        else $error("bit tick late");
    a_bit_not_early: assert property (bit_tick && ok_q && !ext_q |-> cnt_q == per - 20'h1)
        else $error("bit tick early");
    a_ext_sixteen: assert property (bit_tick && ok_q && ext_q |-> ecnt_q == 5'h10)
        else $error("external bit not sixteen edges");
    a_bit_sixteen: assert property (bit_tick && ok_q |-> sample_tick && scnt_q == 4'hF)
        else $error("bit tick not on sixteenth sample");
    a_loop_idle: assert property (lp_q && $past(lp_q) |-> txd_pin)
        else $error("txd not idle in loop-back");
    a_loop_echo: assert property (lp_q && $past(lp_q) |-> rxd_eng == $past(txd_eng))
        else $error("loop-back echo wrong");
    a_txd_follow: assert property (up_q[3] && !lp_q && !$past(lp_q) |-> txd_pin == $past(txd_eng))
        else $error("txd does not follow engine");
    a_tx_flush: assert property (txr_q && $past(txr_q, 3) |-> !tx_avail)
        else $error("tx fifo not held empty");
    a_ready_one: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    // main scenarios reached
    c_ext: cover property (bit_tick && ok_q && ext_q);
    c_loop: cover property (lp_q && rxd_eng);
    c_slow: cover property (bit_tick && ok_q && pre_q == 2'h3);
endmodule : fur_top_properties

// ---- bench/fur_line_model.sv ----
// remote serial device: line level and external rate clock
`timescale 1ns/1ns
module fur_line_model (
    // clock, controls
    input  wire logic mclk,
    input  wire logic run,
    input  wire logic brk,
    // line
    output logic      rxd_pin,
    output logic      ext_clk_pin
);
    logic [2:0] ph_q = 3'h0;
    // external clock at mclk over 8, standing still while not running
    always_ff @(posedge mclk) begin
        if (run) begin
            ph_q <= ph_q + 3'h1;
        end
    end
    assign ext_clk_pin = ph_q[2];
    // mark level while idle, space while breaking
    assign rxd_pin = ~brk;
endmodule : fur_line_model

// ---- bench/fur_top_tb.sv ----
// self-checking bench for the serial rate/fifo block
`timescale 1ns/1ns
`include "fur_params.svh"
module fur_top_tb;
    logic        mclk = 1'b0, rstn = 1'b0, ce = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, rx_byte = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, er;
    logic        txd_eng = 1'b1, tx_pop = 1'b0, rx_push = 1'b0, run = 1'b0, brk = 1'b0;
    logic        pready, pslverr, irq, txd_pin, rxd_eng, tx_avail;
    logic        sample_tick, bit_tick, rxd_pin, ext_clk_pin;
    logic [31:0] prdata;
    logic [7:0]  tx_byte;
    int          miscompares = 0, n_checks = 0;
    // clock
    always #2 mclk = ~mclk;
    fur_top dut (.mclk(mclk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq(irq), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
        .ext_clk_pin(ext_clk_pin), .txd_eng(txd_eng), .rxd_eng(rxd_eng), .tx_avail(tx_avail),
        .tx_byte(tx_byte), .tx_pop(tx_pop), .rx_push(rx_push), .rx_byte(rx_byte),
        .sample_tick(sample_tick), .bit_tick(bit_tick));
    fur_line_model u_line (.mclk(mclk), .run(run), .brk(brk), .rxd_pin(rxd_pin),
        .ext_clk_pin(ext_clk_pin));
    task automatic summarize;
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic tmo;
        miscompares++;
        summarize();
    endtask : tmo
    // one apb transfer; read data and error taken at the completing edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) tmo();
        rd      = prdata;
        er      = {31'h0, pslverr};
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic push(input logic [7:0] b);
        @(posedge mclk);
        rx_push <= 1'b1;
        rx_byte <= b;
        @(posedge mclk);
        rx_push <= 1'b0;
    endtask : push
    // cycles from one bit tick to the next
    task automatic gap(output int n);
        int i;
        for (i = 0; i < 5000; i++) begin
            @(posedge mclk);
            if (bit_tick === 1'b1) break;
        end
        for (n = 1; n < 5000; n++) begin
            @(posedge mclk);
            if (bit_tick === 1'b1) break;
        end
        if (n == 5000 || i == 5000) tmo();
    endtask : gap
    task automatic t_reset;
        apb(1'b0, `FUR_OFS_DIVISOR, 32'h0);
        chk(rd, 32'hFF);
        apb(1'b0, `FUR_OFS_FIFO_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `FUR_OFS_DIVISOR, 32'h5A);
        apb(1'b0, `FUR_OFS_DIVISOR, 32'h0);
        chk(rd, 32'h5A);
        apb(1'b1, 8'h20, 32'h1);
        chk(er, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
    endtask : t_reset
    task automatic t_trig;
        int k, j;
        int thr [4] = '{1, 4, 8, 14};
        apb(1'b1, `FUR_OFS_IRQ_MASK, 32'h1);
        for (k = 0; k < 4; k++) begin
            apb(1'b1, `FUR_OFS_FIFO_CTRL, {24'h0, k[1:0], 6'h02});
            apb(1'b0, `FUR_OFS_COUNT, 32'h0);
            chk(rd & 32'h1F, 32'h0);
            apb(1'b1, `FUR_OFS_FIFO_CTRL, {24'h0, k[1:0], 6'h00});
            apb(1'b0, `FUR_OFS_FIFO_CTRL, 32'h0);
            chk(rd, {24'h0, k[1:0], 6'h00});
            apb(1'b1, `FUR_OFS_STATUS, 32'h1);
            for (j = 0; j < thr[k]; j++) push(8'h30 + j[7:0]);
            apb(1'b0, `FUR_OFS_STATUS, 32'h0);
            chk(rd & 32'h1, 32'h0);
            push(8'hA5);
            apb(1'b0, `FUR_OFS_STATUS, 32'h0);
            chk(rd & 32'h1, 32'h1);
            chk({31'h0, irq}, 32'h1);
            apb(1'b0, `FUR_OFS_RX_DATA, 32'h0);
            chk(rd, 32'h30);
            apb(1'b1, `FUR_OFS_STATUS, 32'h1);
            apb(1'b0, `FUR_OFS_COUNT, 32'h0);
            chk(rd & 32'h1F, thr[k]);
            apb(1'b0, `FUR_OFS_STATUS, 32'h0);
            chk(rd & 32'h1, 32'h0);
            chk({31'h0, irq}, 32'h0);
            if (k > 0) begin
                apb(1'b1, `FUR_OFS_FIFO_CTRL, {24'h0, k[1:0] - 2'h1, 6'h00});
                apb(1'b0, `FUR_OFS_STATUS, 32'h0);
                chk(rd & 32'h1, 32'h1);
            end
        end
        apb(1'b1, `FUR_OFS_IRQ_MASK, 32'h0);
        apb(1'b0, `FUR_OFS_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask : t_trig
    task automatic t_tx;
        apb(1'b1, `FUR_OFS_TX_DATA, 32'h11);
        apb(1'b1, `FUR_OFS_TX_DATA, 32'h22);
        repeat (3) @(posedge mclk);
        chk({23'h0, tx_avail, tx_byte}, 32'h111);
        tx_pop <= 1'b1;
        @(posedge mclk);
        tx_pop <= 1'b0;
        repeat (4) @(posedge mclk);
        chk({23'h0, tx_avail, tx_byte}, 32'h122);
        apb(1'b1, `FUR_OFS_FIFO_CTRL, 32'h04);
        apb(1'b0, `FUR_OFS_COUNT, 32'h0);
        chk({31'h0, tx_avail}, 32'h0);
        chk(rd & 32'h1F00, 32'h0);
        apb(1'b1, `FUR_OFS_FIFO_CTRL, 32'h00);
    endtask : t_tx
    task automatic t_rate;
        int k, n;
        logic [7:0] dv [4] = '{8'h00, 8'h02, 8'h01, 8'h00};
        int per [4] = '{32, 384, 1024, 2048};
        for (k = 0; k < 4; k++) begin
            apb(1'b1, `FUR_OFS_MODE, k);
            apb(1'b1, `FUR_OFS_DIVISOR, {24'h0, dv[k]});
            gap(n);
            gap(n);
            chk(n, per[k]);
        end
        // a frozen clock enable stretches the bit period by the frozen cycles
        gap(n);
        ce <= 1'b0;
        repeat (1000) @(posedge mclk);
        ce <= 1'b1;
        for (n = 1001; n < 5000; n++) begin
            @(posedge mclk);
            if (bit_tick === 1'b1) break;
        end
        if (n == 5000) tmo();
        chk(n, 32'd3048);
    endtask : t_rate
    task automatic t_ext;
        int n;
        apb(1'b1, `FUR_OFS_MODE, 32'h4);
        run <= 1'b1;
        gap(n);
        gap(n);
        chk(n, 32'd128);
        run <= 1'b0;
        apb(1'b1, `FUR_OFS_MODE, 32'h0);
    endtask : t_ext
    task automatic t_loop;
        int j;
        apb(1'b1, `FUR_OFS_FIFO_CTRL, 32'h1);
        brk <= 1'b1;
        for (j = 0; j < 10; j++) begin
            @(posedge mclk);
            txd_eng <= j[0];
            if (j > 1) chk({30'h0, txd_pin, rxd_eng}, {30'h0, 1'b1, j[0]});
        end
        apb(1'b1, `FUR_OFS_FIFO_CTRL, 32'h0);
        txd_eng <= 1'b1;
        repeat (8) @(posedge mclk);
        chk({30'h0, txd_pin, rxd_eng}, 32'h2);
    endtask : t_loop
    // reset, then the scenarios
    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset();
        t_trig();
        t_tx();
        t_rate();
        t_ext();
        t_loop();
        summarize();
    end
endmodule : fur_top_tb
bind fur_top fur_top_properties u_prop (.mclk(mclk), .rstn(rstn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
    .txd_pin(txd_pin), .txd_eng(txd_eng), .rxd_eng(rxd_eng), .tx_avail(tx_avail),
    .ext_clk_pin(ext_clk_pin), .bit_tick(bit_tick), .sample_tick(sample_tick));
